//--- bench/ssm_dev_model.sv
// Behavioural slave device answering the master's port
`timescale 1ns/10ps
module ssm_dev_model
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic req_in,
   input wire logic kind_in,
   input wire logic [31:0] data_in,
   input wire logic slow_in,
   input wire logic err_in,
   output logic done_out,
   output logic fail_out,
   output logic tgl_out,
   output logic [15:0] report_out
);
   logic [3:0] st, tgt;
   logic [2:0] cnt, rc;
   logic fl, ok;
   assign tgt = data_in[3:0];
   assign ok = $onehot(tgt) && data_in[7:5] == 3'h0 && !err_in &&
      !(st == 4'h1 && tgt[3:2] != 2'h0) && !(st == 4'h2 && tgt[3]);
   // Released fail line shows its inverse
   assign fail_out = done_out ? fl : !fl;
   always @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         {done_out, fl, tgl_out, cnt, rc} <= '0;
         st <= 4'h1;
         report_out <= 16'h0001;
      end
      else
      begin
         if (!req_in)
            done_out <= 1'b0;
         else if (!done_out)
         begin
            cnt <= cnt + 3'h1;
            if (cnt >= (slow_in ? 3'h5 : 3'h0))
            begin
               done_out <= 1'b1;
               cnt <= 3'h0;
               fl <= !kind_in && st != 4'h2;
               if (kind_in)
               begin
                  // Toggle late, once the host waits
                  rc <= 3'h7;
                  if (ok)
                     st <= tgt;
                  report_out <= ok ? {12'h000, tgt} : {11'h000, 1'b1, st};
               end
            end
         end
         if (rc != 3'h0)
         begin
            rc <= rc - 3'h1;
            if (rc == 3'h1)
               tgl_out <= !tgl_out;
         end
      end
   end
endmodule : ssm_dev_model

//--- bench/ssm_master_props.sv
// Checker on the master's status and device ports
`timescale 1ns/10ps
module ssm_master_props
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic error_out,
   input wire logic [3:0] cur_state_out,
   input wire logic [15:0] report_out,
   input wire logic dev_req_out,
   input wire logic dev_kind_out,
   input wire logic [15:0] dev_index_out,
   input wire logic [7:0] dev_sub_out,
   input wire logic [1:0] dev_size_out,
   input wire logic [31:0] dev_data_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   // Open request by kind
   wire ctl = dev_req_out && dev_kind_out;
   wire obj = dev_req_out && !dev_kind_out;
   // Request word and steps
   chk_req_onehot: assert property (ctl |-> $onehot(dev_data_out[3:0]))
      else $error("request not one-hot");
   chk_rsvd_zero: assert property (ctl |-> dev_data_out[7:5] == 3'h0)
      else $error("reserved bits set");
   chk_init_step: assert property (ctl && cur_state_out ==
      ssm_pkg::STATE_INIT |-> dev_data_out[3:2] == 2'h0)
      else $error("init skipped pre-op");
   chk_preop_step: assert property (ctl && cur_state_out ==
      ssm_pkg::STATE_PREOP |-> !dev_data_out[3])
      else $error("pre-op jumped to op");
   // Object writes
   chk_obj_preop: assert property (obj |->
      cur_state_out == ssm_pkg::STATE_PREOP)
      else $error("object write outside pre-op");
   chk_count_size: assert property (obj && dev_sub_out == 8'h00
      |-> dev_size_out == ssm_pkg::SIZE_8)
      else $error("count write not one byte");
   chk_entry_size: assert property (obj && dev_index_out[15:12] ==
      4'h1 && dev_index_out[11:8] != 4'hC && dev_sub_out != 8'h00
      |-> dev_size_out == ssm_pkg::SIZE_32 && dev_sub_out <= 8'h08)
      else $error("mapping entry malformed");
   chk_slot_index: assert property (obj && dev_index_out[15:8] ==
      8'h1C && dev_sub_out != 8'h00 |-> dev_sub_out <= 8'h04 &&
      dev_data_out[15:8] == (dev_index_out[0] ? 8'h1A : 8'h16))
      else $error("wrong slot index");
   // Handshake
   chk_payload_hold: assert property (dev_req_out && $past(dev_req_out)
      |-> $stable(dev_data_out) && $stable(dev_index_out))
      else $error("payload moved during request");
   chk_done_pulse: assert property (done_out |-> !busy_out ##1 !done_out)
      else $error("done pulse malformed");
   chk_err_flag: assert property ($rose(report_out[4]) |->
      ##[0:3] error_out)
      else $error("error not raised");
endmodule : ssm_master_props

bind ssm_master ssm_master_props u_ssm_master_props (.*);

//--- bench/tb.sv
// Self-checking bench for the slave state machine master
`timescale 1ns/10ps
module tb;
   logic clock_in, reset_n_in, cmd_state_in, cmd_ack_in, map_wr_in;
   logic cmd_remap_in, remap_tx_in, slow, err, req_d;
   logic [3:0] cmd_target_in, remap_count_in, cur_state_out;
   logic [7:0] cmd_app_in, map_sub_in, map_len_in, dev_sub_out;
   logic [2:0] map_sel_in, remap_sm_count_in;
   logic [15:0] map_obj_in, dev_index_out, report_out, dev_report_in;
   logic [1:0] remap_pdo_in, remap_slot_in, dev_size_out;
   logic busy_out, done_out, error_out, dev_req_out, dev_kind_out;
   logic dev_done_in, dev_fail_in, dev_report_tgl_in;
   logic [31:0] dev_data_out, ctl;
   logic [55:0] lq[$];
   int mismatches, num_checks;
   ssm_master u_ssm_master (.*);
   ssm_dev_model u_ssm_dev_model (.clock_in, .reset_n_in,
      .req_in(dev_req_out), .kind_in(dev_kind_out), .data_in(dev_data_out),
      .slow_in(slow), .err_in(err), .done_out(dev_done_in),
      .fail_out(dev_fail_in), .tgl_out(dev_report_tgl_in),
      .report_out(dev_report_in));
   // Clock at 100 ns
   initial
   begin
      clock_in = 1'b0;
      forever #50 clock_in = !clock_in;
   end
   // Log each object access as it opens, masked to size; keep the last control word unmasked
   always @(posedge clock_in)
   begin
      req_d <= dev_req_out;
      if (dev_req_out && !req_d && dev_kind_out)
         ctl <= dev_data_out;
      else if (dev_req_out && !req_d)
         lq.push_back({dev_index_out, dev_sub_out, dev_data_out &
            ~(32'hFFFF_FFFF << (8 << dev_size_out))});
   end
   task automatic results;
      if (mismatches == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   task automatic check(input logic [55:0] s, e);
      num_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask : check
   // Pulse a command, wait bounded for its end
   task automatic run(input logic st, rm);
      int n;
      @(posedge clock_in) #1;
      {cmd_state_in, cmd_remap_in} = {st, rm};
      @(posedge clock_in) #1;
      {cmd_state_in, cmd_remap_in} = 2'h0;
      for (n = 0; n < 3000 && busy_out !== 1'b0; n++)
         @(posedge clock_in) #1;
      if (n == 3000)
      begin
         mismatches++;
         results();
      end
   endtask : run
   task automatic go(input logic [3:0] t);
      cmd_target_in = t;
      run(1'b1, 1'b0);
   endtask : go
   task automatic load(input logic [2:0] s, input logic [31:0] v);
      @(posedge clock_in) #1;
      {map_wr_in, map_sel_in} = {1'b1, s};
      {map_obj_in, map_sub_in, map_len_in} = v;
      @(posedge clock_in) #1;
      map_wr_in = 1'b0;
   endtask : load
   task automatic remap(input logic [3:0] c, input logic [2:0] m);
      {remap_count_in, remap_sm_count_in} = {c, m};
      lq.delete();
      run(1'b0, 1'b1);
   endtask : remap
   // Reset, then walk states and remap
   initial
   begin
      {cmd_state_in, cmd_ack_in, map_wr_in, cmd_remap_in, slow, err} = '0;
      {cmd_target_in, cmd_app_in, map_sel_in, map_obj_in} = '0;
      {map_sub_in, map_len_in, remap_tx_in, remap_pdo_in} = '0;
      {remap_count_in, remap_slot_in, remap_sm_count_in} = '0;
      reset_n_in = 1'b0;
      repeat (6) @(posedge clock_in);
      #1 reset_n_in = 1'b1;
      check(report_out, ssm_pkg::RPT_RESET);
      {cmd_ack_in, cmd_app_in} = {1'b1, 8'hA5};
      go(ssm_pkg::STATE_OP);
      check({error_out, cur_state_out}, ssm_pkg::STATE_OP);
      check(ctl, {16'h0000, 8'hA5, 4'h1, ssm_pkg::STATE_OP});
      go(ssm_pkg::STATE_PREOP);
      check(cur_state_out, ssm_pkg::STATE_PREOP);
      go(ssm_pkg::STATE_INIT);
      slow = 1'b1;
      go(ssm_pkg::STATE_SAFEOP);
      check(cur_state_out, ssm_pkg::STATE_SAFEOP);
      err = 1'b1;
      go(ssm_pkg::STATE_OP);
      check({error_out, cur_state_out, report_out}, 21'h14_0014);
      err = 1'b0;
      load(3'h0, 32'h6040_0010);
      load(3'h1, 32'h6060_0008);
      {remap_tx_in, remap_pdo_in, remap_slot_in} = {1'b0, 2'h2, 2'h2};
      remap(4'h2, 3'h3);
      check(cur_state_out, ssm_pkg::STATE_OP);
      check(lq.size(), 7);
      check(lq[0], {16'h1602, 8'h00, 32'h0000_0000});
      check(lq[1], {16'h1602, 8'h01, 32'h6040_0010});
      check(lq[2], {16'h1602, 8'h02, 32'h6060_0008});
      check(lq[3], {16'h1602, 8'h00, 32'h0000_0002});
      check(lq[4], {16'h1C12, 8'h00, 32'h0000_0000});
      check(lq[5], {16'h1C12, 8'h03, 32'h0000_1602});
      check(lq[6], {16'h1C12, 8'h00, 32'h0000_0003});
      remap(4'h9, 3'h3);
      check({busy_out, error_out, 8'(lq.size())}, 10'h100);
      remap(4'h1, 3'h2);
      check({busy_out, error_out, 8'(lq.size())}, 10'h100);
      {remap_tx_in, remap_pdo_in, remap_slot_in} = {1'b1, 2'h1, 2'h0};
      remap(4'h0, 3'h1);
      check(lq[0], {16'h1A01, 40'h0});
      check({cur_state_out, 8'(lq.size())}, {4'h2, 8'h01});
      results();
   end
endmodule : tb

//--- common/ssm_acc_if.sv
// Carrier between the sequencer and the device access engine
`timescale 1ns/10ps
interface ssm_acc_if;
   logic start;
   logic kind;
   logic [15:0] index;
   logic [7:0] sub;
   logic [1:0] size;
   logic [31:0] data;
   logic busy;
   logic done;
   logic fail;

   modport ctl (output start, kind, index, sub, size, data,
                input busy, done, fail);
   modport eng (input start, kind, index, sub, size, data,
                output busy, done, fail);
endinterface : ssm_acc_if

//--- common/ssm_pkg.sv
// Shared constants and types for the slave state machine master
package ssm_pkg;

   // One-hot codes of the state field in the request and report words
   localparam logic [3:0] STATE_INIT = 4'h1;
   localparam logic [3:0] STATE_PREOP = 4'h2;
   localparam logic [3:0] STATE_SAFEOP = 4'h4;
   localparam logic [3:0] STATE_OP = 4'h8;

   // Field positions of the state request word
   localparam int REQ_STATE_LSB = 0;
   localparam int REQ_ACK_BIT = 4;
   localparam int REQ_RSVD_LSB = 5;
   localparam int REQ_APP_LSB = 8;

   // Field positions of the state report word
   localparam int RPT_STATE_LSB = 0;
   localparam int RPT_ERR_BIT = 4;

   // Object indexes used by the remapping procedure
   localparam logic [15:0] RX_MAP_BASE = 16'h1600;
   localparam logic [15:0] TX_MAP_BASE = 16'h1A00;
   localparam logic [15:0] SM_RX_INDEX = 16'h1C12;
   localparam logic [15:0] SM_TX_INDEX = 16'h1C13;
   localparam logic [7:0] SUB_COUNT = 8'h00;

   // Mapping entry layout: index, sub-index, length in bits
   localparam int MAP_OBJ_LSB = 16;
   localparam int MAP_SUB_LSB = 8;
   localparam int MAP_LEN_LSB = 0;
   localparam int MAP_ENTRIES = 8;
   localparam logic [3:0] MAP_MAX = 4'h8;
   localparam logic [2:0] SM_SLOT_MAX = 3'h4;

   // Access kinds and sizes on the device port
   localparam logic KIND_OBJ = 1'b0;
   localparam logic KIND_CTRL = 1'b1;
   localparam logic [1:0] SIZE_8 = 2'h0;
   localparam logic [1:0] SIZE_16 = 2'h1;
   localparam logic [1:0] SIZE_32 = 2'h2;

   // Values after reset
   localparam logic [15:0] RPT_RESET = 16'h0001;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   // Sequencer states, Gray coded in listing order; steps back to SSM_HOP and into SSM_PDO_OFF change more than one bit,
   // as do aborts to SSM_IDLE from every access state but SSM_SM_OFF
   typedef enum logic [3:0] {
      SSM_IDLE = 4'h0,
      SSM_HOP = 4'h1,
      SSM_CTRL = 4'h3,
      SSM_WAIT_RPT = 4'h2,
      SSM_PDO_OFF = 4'h6,
      SSM_MAP = 4'h7,
      SSM_PDO_ON = 4'h5,
      SSM_SM_OFF = 4'h4,
      SSM_SM_SLOT = 4'hC,
      SSM_SM_ON = 4'hD
   } ssm_main_e;

   // Access engine states
   typedef enum logic [1:0] {
      SSM_ACC_IDLE = 2'h0,
      SSM_ACC_HI = 2'h1,
      SSM_ACC_LO = 2'h3
   } ssm_acc_e;

endpackage : ssm_pkg

//--- logic/ssm_access.sv
// Four-phase access engine toward the device port
`timescale 1ns/10ps
module ssm_access
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   ssm_acc_if.eng acc,
   output logic dev_req_out,
   output logic dev_kind_out,
   output logic [15:0] dev_index_out,
   output logic [7:0] dev_sub_out,
   output logic [1:0] dev_size_out,
   output logic [31:0] dev_data_out,
   input wire logic dev_done_in,
   input wire logic dev_fail_in
);
   ssm_pkg::ssm_acc_e st_reg;
   ssm_pkg::ssm_acc_e st_next;
   logic done_s1_reg;
   logic done_s2_reg;
   logic fail_s1_reg;
   logic fail_s2_reg;
   logic fail_cap_reg;
   logic done_reg;
   logic fail_reg;
   wire logic take;
   wire logic acked;
   wire logic released;

   // Decode of the handshake phases
   assign take = (st_reg == ssm_pkg::SSM_ACC_IDLE) && acc.start;
   assign acked = (st_reg == ssm_pkg::SSM_ACC_HI) && done_s2_reg;
   assign released = (st_reg == ssm_pkg::SSM_ACC_LO) && !done_s2_reg;
   assign acc.busy = (st_reg != ssm_pkg::SSM_ACC_IDLE);
   assign acc.done = done_reg;
   assign acc.fail = fail_reg;

   // Next state: request up, wait acknowledge, wait its release
   always_comb
   begin
      st_next = st_reg;
      case (st_reg)
         ssm_pkg::SSM_ACC_IDLE: if (take) st_next = ssm_pkg::SSM_ACC_HI;
         ssm_pkg::SSM_ACC_HI: if (acked) st_next = ssm_pkg::SSM_ACC_LO;
         ssm_pkg::SSM_ACC_LO: if (released) st_next = ssm_pkg::SSM_ACC_IDLE;
         default: st_next = ssm_pkg::SSM_ACC_IDLE;
      endcase
   end

   // Device answers are asynchronous, so two flops before use
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         done_s1_reg <= 1'b0;
         done_s2_reg <= 1'b0;
         fail_s1_reg <= 1'b0;
         fail_s2_reg <= 1'b0;
      end
      else
      begin
         done_s1_reg <= dev_done_in;
         done_s2_reg <= done_s1_reg;
         fail_s1_reg <= dev_fail_in;
         fail_s2_reg <= fail_s1_reg;
      end
   end

   // State and completion pulses
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         st_reg <= ssm_pkg::SSM_ACC_IDLE;
         fail_cap_reg <= 1'b0;
         done_reg <= 1'b0;
         fail_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         if (acked)
            fail_cap_reg <= fail_s2_reg;
         done_reg <= released;
         fail_reg <= released && fail_cap_reg;
      end
   end

   // Request and its payload are held steady through the handshake
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         dev_req_out <= 1'b0;
         dev_kind_out <= ssm_pkg::KIND_OBJ;
         dev_index_out <= 16'h0000;
         dev_sub_out <= 8'h00;
         dev_size_out <= ssm_pkg::SIZE_8;
         dev_data_out <= ssm_pkg::WORD_RESET;
      end
      else
      begin
         if (take)
         begin
            dev_req_out <= 1'b1;
            dev_kind_out <= acc.kind;
            dev_index_out <= acc.index;
            dev_sub_out <= acc.sub;
            dev_size_out <= acc.size;
            dev_data_out <= acc.data;
         end
         else if (acked)
            dev_req_out <= 1'b0;
      end
   end
endmodule : ssm_access

//--- logic/ssm_master.sv
// Master side sequencer for slave state changes and process data remap
`timescale 1ns/10ps
module ssm_master
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   // State change command
   input wire logic cmd_state_in,
   input wire logic [3:0] cmd_target_in,
   input wire logic cmd_ack_in,
   input wire logic [7:0] cmd_app_in,
   // Mapping entry load
   input wire logic map_wr_in,
   input wire logic [2:0] map_sel_in,
   input wire logic [15:0] map_obj_in,
   input wire logic [7:0] map_sub_in,
   input wire logic [7:0] map_len_in,
   // Remap command
   input wire logic cmd_remap_in,
   input wire logic remap_tx_in,
   input wire logic [1:0] remap_pdo_in,
   input wire logic [3:0] remap_count_in,
   input wire logic [1:0] remap_slot_in,
   input wire logic [2:0] remap_sm_count_in,
   // Status toward the user
   output logic busy_out,
   output logic done_out,
   output logic error_out,
   output logic [3:0] cur_state_out,
   output logic [15:0] report_out,
   // Device port
   output logic dev_req_out,
   output logic dev_kind_out,
   output logic [15:0] dev_index_out,
   output logic [7:0] dev_sub_out,
   output logic [1:0] dev_size_out,
   output logic [31:0] dev_data_out,
   input wire logic dev_done_in,
   input wire logic dev_fail_in,
   input wire logic dev_report_tgl_in,
   input wire logic [15:0] dev_report_in
);
   ssm_acc_if acc ();

   ssm_pkg::ssm_main_e st_reg;
   ssm_pkg::ssm_main_e st_next;
   logic [31:0] map_mem [0:ssm_pkg::MAP_ENTRIES-1];
   logic [3:0] tgt_reg;
   logic [3:0] hop_reg;
   logic ack_reg;
   logic [7:0] app_reg;
   logic remap_pend_reg;
   logic tx_reg;
   logic [1:0] pdo_reg;
   logic [3:0] count_reg;
   logic [1:0] slot_reg;
   logic [2:0] sm_count_reg;
   logic [2:0] entry_reg;
   logic issued_reg;
   logic tgl_s1_reg;
   logic tgl_s2_reg;
   logic tgl_s3_reg;
   logic [15:0] rpt_s1_reg;
   logic [15:0] rpt_s2_reg;

   wire logic idle;
   wire logic rpt_event;
   wire logic rpt_err;
   wire logic [3:0] rpt_state;
   wire logic rpt_bad;
   wire logic [3:0] hop;
   wire logic at_target;
   wire logic acc_state;
   wire logic acc_ok;
   wire logic acc_bad;
   wire logic take_state;
   wire logic take_remap;
   wire logic remap_bad;
   wire logic last_entry;
   wire logic [15:0] map_index;
   wire logic [15:0] sm_index;
   wire logic [15:0] req_word;
   wire logic fail_now;

   // Next legal step toward the target; init only leaves to pre-op,
   // pre-op reaches op through safe-op
   function automatic logic [3:0] next_hop(input logic [3:0] cur,
                                           input logic [3:0] tgt);
      logic [3:0] h;
      h = tgt;
      if (cur == ssm_pkg::STATE_INIT && tgt != ssm_pkg::STATE_INIT)
         h = ssm_pkg::STATE_PREOP;
      else if (cur == ssm_pkg::STATE_PREOP && tgt == ssm_pkg::STATE_OP)
         h = ssm_pkg::STATE_SAFEOP;
      return h;
   endfunction : next_hop

   ssm_access u_access
   (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .acc(acc),
      .dev_req_out(dev_req_out),
      .dev_kind_out(dev_kind_out),
      .dev_index_out(dev_index_out),
      .dev_sub_out(dev_sub_out),
      .dev_size_out(dev_size_out),
      .dev_data_out(dev_data_out),
      .dev_done_in(dev_done_in),
      .dev_fail_in(dev_fail_in)
   );

   // Report decode; the data is stable once its toggle has crossed
   assign rpt_event = tgl_s2_reg ^ tgl_s3_reg;
   assign rpt_state = rpt_s2_reg[ssm_pkg::RPT_STATE_LSB +: 4];
   assign rpt_err = rpt_s2_reg[ssm_pkg::RPT_ERR_BIT];
   // a set error flag or a state other than the step fails it
   assign rpt_bad = rpt_err || (rpt_state != hop_reg);

   // walk one permitted step at a time
   assign hop = next_hop(cur_state_out, tgt_reg);
   assign at_target = (cur_state_out == tgt_reg);

   // Command acceptance; anything arriving while busy is ignored
   assign idle = (st_reg == ssm_pkg::SSM_IDLE);
   assign take_state = idle && cmd_state_in;
   assign take_remap = idle && !cmd_state_in && cmd_remap_in;
   // more than eight entries cannot be mapped
   assign remap_bad = (remap_count_in > ssm_pkg::MAP_MAX) ||
                      (remap_sm_count_in > ssm_pkg::SM_SLOT_MAX) ||
                      ({1'b0, remap_slot_in} >= remap_sm_count_in);

   // States that drive one access through the engine
   assign acc_state = (st_reg == ssm_pkg::SSM_CTRL) ||
                      (st_reg == ssm_pkg::SSM_PDO_OFF) ||
                      (st_reg == ssm_pkg::SSM_MAP) ||
                      (st_reg == ssm_pkg::SSM_PDO_ON) ||
                      (st_reg == ssm_pkg::SSM_SM_OFF) ||
                      (st_reg == ssm_pkg::SSM_SM_SLOT) ||
                      (st_reg == ssm_pkg::SSM_SM_ON);
   assign acc_ok = acc_state && acc.done && !acc.fail;
   assign acc_bad = acc_state && acc.fail;
   assign fail_now = acc_bad ||
                     ((st_reg == ssm_pkg::SSM_WAIT_RPT) && rpt_event &&
                      rpt_bad);
   assign last_entry = ({1'b0, entry_reg} == count_reg - 4'h1);

   // receive maps go to 1C12h slots, transmit maps to 1C13h
   assign map_index = (tx_reg ? ssm_pkg::TX_MAP_BASE
                              : ssm_pkg::RX_MAP_BASE) + {14'h0000, pdo_reg};
   assign sm_index = tx_reg ? ssm_pkg::SM_TX_INDEX : ssm_pkg::SM_RX_INDEX;

   // reserved bits zero, application byte on top
   assign req_word = {app_reg, 3'b000, ack_reg, hop_reg};

   // Access parameters per sequencer state
   assign acc.start = acc_state && !issued_reg && !acc.busy;
   assign acc.kind = (st_reg == ssm_pkg::SSM_CTRL) ? ssm_pkg::KIND_CTRL
                                                   : ssm_pkg::KIND_OBJ;
   assign acc.index = (st_reg == ssm_pkg::SSM_CTRL) ? 16'h0000 :
                      (st_reg == ssm_pkg::SSM_SM_OFF ||
                       st_reg == ssm_pkg::SSM_SM_SLOT ||
                       st_reg == ssm_pkg::SSM_SM_ON) ? sm_index : map_index;
   assign acc.sub = (st_reg == ssm_pkg::SSM_MAP) ?
                       {5'h00, entry_reg} + 8'h01 :
                    (st_reg == ssm_pkg::SSM_SM_SLOT) ?
                       {6'h00, slot_reg} + 8'h01 : ssm_pkg::SUB_COUNT;
   assign acc.size = (st_reg == ssm_pkg::SSM_CTRL ||
                      st_reg == ssm_pkg::SSM_SM_SLOT) ? ssm_pkg::SIZE_16 :
                     (st_reg == ssm_pkg::SSM_MAP) ? ssm_pkg::SIZE_32
                                                  : ssm_pkg::SIZE_8;
   // zero count first disables the mapping
   // entry count written last re-enables it
   // channel count zeroed before its slot changes
   // channel count written last re-enables it
   assign acc.data = (st_reg == ssm_pkg::SSM_CTRL) ? {16'h0000, req_word} :
                     (st_reg == ssm_pkg::SSM_MAP) ? map_mem[entry_reg] :
                     (st_reg == ssm_pkg::SSM_PDO_ON) ?
                        {28'h000_0000, count_reg} :
                     (st_reg == ssm_pkg::SSM_SM_SLOT) ?
                        {16'h0000, map_index} :
                     (st_reg == ssm_pkg::SSM_SM_ON) ?
                        {29'h0000_0000, sm_count_reg} : ssm_pkg::WORD_RESET;

   // Sequencer next state
   always_comb
   begin
      st_next = st_reg;
      case (st_reg)
         ssm_pkg::SSM_IDLE:
            if (take_state || (take_remap && !remap_bad))
               st_next = ssm_pkg::SSM_HOP;
         ssm_pkg::SSM_HOP:
            if (!at_target)
               st_next = ssm_pkg::SSM_CTRL;
            else if (remap_pend_reg)
               st_next = ssm_pkg::SSM_PDO_OFF;
            else
               st_next = ssm_pkg::SSM_IDLE;
         // the request write is answered by a report
         ssm_pkg::SSM_CTRL:
            if (acc_bad)
               st_next = ssm_pkg::SSM_IDLE;
            else if (acc_ok)
               st_next = ssm_pkg::SSM_WAIT_RPT;
         // a refused step ends the walk where the slave stays
         ssm_pkg::SSM_WAIT_RPT:
            if (rpt_event)
               st_next = rpt_bad ? ssm_pkg::SSM_IDLE : ssm_pkg::SSM_HOP;
         ssm_pkg::SSM_PDO_OFF:
            if (acc_bad)
               st_next = ssm_pkg::SSM_IDLE;
            else if (acc_ok)
               st_next = (count_reg == 4'h0) ? ssm_pkg::SSM_HOP
                                             : ssm_pkg::SSM_MAP;
         ssm_pkg::SSM_MAP:
            if (acc_bad)
               st_next = ssm_pkg::SSM_IDLE;
            else if (acc_ok && last_entry)
               st_next = ssm_pkg::SSM_PDO_ON;
         ssm_pkg::SSM_PDO_ON:
            if (acc_bad)
               st_next = ssm_pkg::SSM_IDLE;
            else if (acc_ok)
               st_next = ssm_pkg::SSM_SM_OFF;
         // channel writes happen in pre-op after its count is zero
         ssm_pkg::SSM_SM_OFF:
            if (acc_bad)
               st_next = ssm_pkg::SSM_IDLE;
            else if (acc_ok)
               st_next = ssm_pkg::SSM_SM_SLOT;
         ssm_pkg::SSM_SM_SLOT:
            if (acc_bad)
               st_next = ssm_pkg::SSM_IDLE;
            else if (acc_ok)
               st_next = ssm_pkg::SSM_SM_ON;
         ssm_pkg::SSM_SM_ON:
            if (acc_bad)
               st_next = ssm_pkg::SSM_IDLE;
            else if (acc_ok)
               st_next = ssm_pkg::SSM_HOP;
         default: st_next = ssm_pkg::SSM_IDLE;
      endcase
   end

   // Report toggle and word cross in two flops; third flop for the edge
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
         rpt_s1_reg <= ssm_pkg::RPT_RESET;
         rpt_s2_reg <= ssm_pkg::RPT_RESET;
      end
      else
      begin
         tgl_s1_reg <= dev_report_tgl_in;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
         rpt_s1_reg <= dev_report_in;
         rpt_s2_reg <= rpt_s1_reg;
      end
   end

   // entry word is index, sub-index and length in bits
   always_ff @(posedge clock_in)
   begin
      if (map_wr_in && idle)
         map_mem[map_sel_in] <= {map_obj_in, map_sub_in, map_len_in};
   end

   // Command capture; a remap first walks to pre-op
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         tgt_reg <= ssm_pkg::STATE_INIT;
         ack_reg <= 1'b0;
         app_reg <= 8'h00;
         remap_pend_reg <= 1'b0;
         tx_reg <= 1'b0;
         pdo_reg <= 2'h0;
         count_reg <= 4'h0;
         slot_reg <= 2'h0;
         sm_count_reg <= 3'h0;
      end
      else if (take_state)
      begin
         tgt_reg <= cmd_target_in;
         ack_reg <= cmd_ack_in;
         app_reg <= cmd_app_in;
         remap_pend_reg <= 1'b0;
      end
      else if (take_remap && !remap_bad)
      begin
         tgt_reg <= ssm_pkg::STATE_PREOP;
         ack_reg <= 1'b0;
         app_reg <= 8'h00;
         remap_pend_reg <= 1'b1;
         tx_reg <= remap_tx_in;
         pdo_reg <= remap_pdo_in;
         count_reg <= remap_count_in;
         slot_reg <= remap_slot_in;
         sm_count_reg <= remap_sm_count_in;
      end
      else if (st_reg == ssm_pkg::SSM_SM_ON && acc_ok)
      begin
         // outputs are configured, so now head for operational
         tgt_reg <= ssm_pkg::STATE_OP;
         remap_pend_reg <= 1'b0;
      end
      else if (st_reg == ssm_pkg::SSM_PDO_OFF && acc_ok &&
               count_reg == 4'h0)
         remap_pend_reg <= 1'b0;
   end

   // Step latch, access bookkeeping and entry counter
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         hop_reg <= ssm_pkg::STATE_INIT;
         issued_reg <= 1'b0;
         entry_reg <= 3'h0;
      end
      else
      begin
         if (st_reg == ssm_pkg::SSM_HOP)
            hop_reg <= hop;
         if (acc.start)
            issued_reg <= 1'b1;
         else if (acc.done)
            issued_reg <= 1'b0;
         if (st_reg == ssm_pkg::SSM_PDO_OFF)
            entry_reg <= 3'h0;
         else if (st_reg == ssm_pkg::SSM_MAP && acc_ok && !last_entry)
            entry_reg <= entry_reg + 3'h1;
      end
   end

   // User status; the mirrored state follows only confirmed steps
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         st_reg <= ssm_pkg::SSM_IDLE;
         // the slave comes up in init
         cur_state_out <= ssm_pkg::STATE_INIT;
         report_out <= ssm_pkg::RPT_RESET;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         error_out <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         if (rpt_event)
            report_out <= rpt_s2_reg;
         // each confirmed step is what starts or stops services
         // a direct downward step is taken as one request
         if (st_reg == ssm_pkg::SSM_WAIT_RPT && rpt_event && !rpt_err)
            cur_state_out <= rpt_state;
         busy_out <= (st_next != ssm_pkg::SSM_IDLE);
         done_out <= !idle && (st_next == ssm_pkg::SSM_IDLE) && !fail_now;
         if (take_state || take_remap)
            error_out <= take_remap && remap_bad;
         else if (fail_now)
            error_out <= 1'b1;
      end
   end
endmodule : ssm_master
